// >>> hdl/nibble_exec_pkg.sv
// Constants for the nibble add, logic and branch execution block.
// Assumes one instruction word of ten bits per instruction cycle.
`default_nettype none

package nibble_exec_pkg;

    // -----------------------------------------------------------------
    // Widths
    // -----------------------------------------------------------------
    localparam int WORD_W = 10;
    localparam int NIB_W = 4;
    localparam int PAGE_W = 5;
    localparam int OFFSET_W = 7;
    localparam int DREG_W = 3;

    // -----------------------------------------------------------------
    // Opcodes
    // -----------------------------------------------------------------
    localparam logic [WORD_W-1:0] OPC_ADD_MEMORY = 10'h00a;
    localparam logic [WORD_W-1:0] OPC_ADD_MEMORY_CARRY = 10'h00b;
    localparam logic [WORD_W-1:0] OPC_AND_MEMORY = 10'h018;
    localparam logic [WORD_W-1:0] OPC_INDIRECT_LONG_JUMP = 10'h010;
    localparam logic [2:0] PFX_IN_PAGE_JUMP = 3'h3;
    localparam logic [4:0] PFX_LONG_JUMP = 5'h07;
    localparam logic [2:0] PFX_SECOND_WORD = 3'h4;

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int PFX3_LSB = 7;
    localparam int PFX5_LSB = 5;
    localparam int IND_PAGE_HI_BIT = 6;
    localparam int IND_PAGE_LO_W = 4;

    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [NIB_W-1:0] ACC_RESET = 4'h0;
    localparam logic CARRY_RESET = 1'b0;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 5'h00;
    localparam logic [OFFSET_W-1:0] OFFSET_RESET = 7'h00;

    typedef enum logic [1:0] {
        ALU_PASS,
        ALU_ADD,
        ALU_ADD_CARRY,
        ALU_AND
    } alu_op_e;

    typedef enum logic [1:0] {
        ST_FIRST,
        ST_LONG_SECOND,
        ST_INDIRECT_SECOND
    } decode_state_e;

endpackage

`default_nettype wire

// >>> hdl/nibble_alu_if.sv
// Carrier between the decoder and its nibble arithmetic unit.
// Assumes the package is compiled first.
`timescale 1ns/10ps
`default_nettype none

interface nibble_alu_if;
    nibble_exec_pkg::alu_op_e op;
    logic [nibble_exec_pkg::NIB_W-1:0] acc;
    logic [nibble_exec_pkg::NIB_W-1:0] operand;
    logic carry_in;
    logic [nibble_exec_pkg::NIB_W-1:0] result;
    logic carry_out;

    modport decoder (output op, output acc, output operand, output carry_in, input result, input carry_out);
    modport unit (input op, input acc, input operand, input carry_in, output result, output carry_out);
endinterface

`default_nettype wire

// >>> hdl/nibble_alu.sv
// Nibble arithmetic unit: add, add with carry, and AND.
// Assumes a purely combinational use by the decoder.
`timescale 1ns/10ps
`default_nettype none

module nibble_alu (
    nibble_alu_if.unit alu
);
    // -----------------------------------------------------------------
    // Arithmetic
    // -----------------------------------------------------------------
    function automatic logic [nibble_exec_pkg::NIB_W:0] nib_sum(
        input logic [nibble_exec_pkg::NIB_W-1:0] x,
        input logic [nibble_exec_pkg::NIB_W-1:0] y,
        input logic c
    );
        nib_sum = {1'b0, x} + {1'b0, y} + {{nibble_exec_pkg::NIB_W{1'b0}}, c};
    endfunction

    logic [nibble_exec_pkg::NIB_W:0] sum;

    always_comb begin
        sum = nib_sum(alu.acc, alu.operand, 1'b0);
        alu.result = alu.acc;
        alu.carry_out = 1'b0;
        case (alu.op)
            nibble_exec_pkg::ALU_ADD: begin
                sum = nib_sum(alu.acc, alu.operand, 1'b0);
                alu.result = sum[nibble_exec_pkg::NIB_W-1:0];
            end
            nibble_exec_pkg::ALU_ADD_CARRY: begin
                sum = nib_sum(alu.acc, alu.operand, alu.carry_in);
                alu.result = sum[nibble_exec_pkg::NIB_W-1:0];
                alu.carry_out = sum[nibble_exec_pkg::NIB_W];
            end
            nibble_exec_pkg::ALU_AND: begin
                alu.result = alu.acc & alu.operand;
            end
            default: begin
                alu.result = alu.acc;
            end
        endcase
    end
endmodule

`default_nettype wire

// >>> hdl/nibble_exec.sv
// Execution of add, add with carry, AND and the three branch forms.
// Assumes the fetch unit presents one word per cycle and the data RAM
// returns the pointed nibble for the current data pointer in the same cycle.
`timescale 1ns/10ps
`default_nettype none

module nibble_exec (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [nibble_exec_pkg::WORD_W-1:0] instr_word,
    input wire logic [nibble_exec_pkg::PAGE_W-1:0] current_page,
    input wire logic [5:0] data_pointer,
    input wire logic [nibble_exec_pkg::NIB_W-1:0] pointed_memory_nibble,
    input wire logic [nibble_exec_pkg::DREG_W-1:0] d_register,
    input wire logic acc_ext_load,
    input wire logic [nibble_exec_pkg::NIB_W-1:0] acc_ext_data,
    output logic [5:0] ram_read_addr,
    output logic [nibble_exec_pkg::NIB_W-1:0] accumulator,
    output logic carry_flag,
    output logic pc_load,
    output logic [nibble_exec_pkg::PAGE_W-1:0] program_page_part,
    output logic [nibble_exec_pkg::OFFSET_W-1:0] program_offset_part,
    output logic second_word_wait
);
    // -----------------------------------------------------------------
    // Decode helpers
    // -----------------------------------------------------------------
    function automatic logic is_second_word(input logic [nibble_exec_pkg::WORD_W-1:0] w);
        is_second_word = w[nibble_exec_pkg::WORD_W-1:nibble_exec_pkg::PFX3_LSB]
            == nibble_exec_pkg::PFX_SECOND_WORD;
    endfunction

    function automatic logic [nibble_exec_pkg::OFFSET_W-1:0] offset_field(
        input logic [nibble_exec_pkg::WORD_W-1:0] w
    );
        offset_field = w[nibble_exec_pkg::OFFSET_W-1:0];
    endfunction

    nibble_exec_pkg::decode_state_e state;
    nibble_exec_pkg::decode_state_e next_state;
    logic [nibble_exec_pkg::PAGE_W-1:0] held_page;
    logic first_word;
    logic dec_in_page;
    logic dec_long;
    logic dec_indirect;
    logic dec_add;
    logic dec_add_carry;
    logic dec_and;
    logic [nibble_exec_pkg::PAGE_W-1:0] indirect_page;
    logic take_long_second;
    logic take_indirect_second;
    logic acc_write;
    logic jump_taken;

    nibble_alu_if alu_bus ();

    nibble_alu u_alu (
        .alu(alu_bus)
    );

    // -----------------------------------------------------------------
    // Instruction decode
    // -----------------------------------------------------------------
    assign first_word = instr_valid && (state == nibble_exec_pkg::ST_FIRST);
    assign dec_add = first_word && (instr_word == nibble_exec_pkg::OPC_ADD_MEMORY);
    assign dec_add_carry = first_word && (instr_word == nibble_exec_pkg::OPC_ADD_MEMORY_CARRY);
    assign dec_and = first_word && (instr_word == nibble_exec_pkg::OPC_AND_MEMORY);
    assign dec_in_page = first_word && (instr_word[nibble_exec_pkg::WORD_W-1:nibble_exec_pkg::PFX3_LSB]
        == nibble_exec_pkg::PFX_IN_PAGE_JUMP);
    assign dec_long = first_word && (instr_word[nibble_exec_pkg::WORD_W-1:nibble_exec_pkg::PFX5_LSB]
        == nibble_exec_pkg::PFX_LONG_JUMP);
    assign dec_indirect = first_word && (instr_word == nibble_exec_pkg::OPC_INDIRECT_LONG_JUMP);
    assign indirect_page = {instr_word[nibble_exec_pkg::IND_PAGE_HI_BIT],
        instr_word[nibble_exec_pkg::IND_PAGE_LO_W-1:0]};
    assign ram_read_addr = data_pointer;
    assign second_word_wait = (state != nibble_exec_pkg::ST_FIRST);

    // -----------------------------------------------------------------
    // Second-word acceptance
    // -----------------------------------------------------------------
    assign take_long_second = instr_valid && (state == nibble_exec_pkg::ST_LONG_SECOND)
        && is_second_word(instr_word);
    assign take_indirect_second = instr_valid && (state == nibble_exec_pkg::ST_INDIRECT_SECOND)
        && is_second_word(instr_word);
    assign acc_write = dec_add || dec_add_carry || dec_and;
    assign jump_taken = dec_in_page || take_long_second || take_indirect_second;

    // -----------------------------------------------------------------
    // Arithmetic hookup
    // -----------------------------------------------------------------
    always_comb begin
        alu_bus.op = nibble_exec_pkg::ALU_PASS;
        if (dec_add) begin
            alu_bus.op = nibble_exec_pkg::ALU_ADD;
        end else if (dec_add_carry) begin
            alu_bus.op = nibble_exec_pkg::ALU_ADD_CARRY;
        end else if (dec_and) begin
            alu_bus.op = nibble_exec_pkg::ALU_AND;
        end
    end

    assign alu_bus.acc = accumulator;
    assign alu_bus.operand = pointed_memory_nibble;
    assign alu_bus.carry_in = carry_flag;

    // -----------------------------------------------------------------
    // Two-word sequencing
    // -----------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            nibble_exec_pkg::ST_FIRST: begin
                if (dec_long) begin
                    next_state = nibble_exec_pkg::ST_LONG_SECOND;
                end else if (dec_indirect) begin
                    next_state = nibble_exec_pkg::ST_INDIRECT_SECOND;
                end
            end
            nibble_exec_pkg::ST_LONG_SECOND, nibble_exec_pkg::ST_INDIRECT_SECOND: begin
                if (instr_valid) begin
                    next_state = nibble_exec_pkg::ST_FIRST;
                end
            end
            default: begin
                next_state = nibble_exec_pkg::ST_FIRST;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= nibble_exec_pkg::ST_FIRST;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            held_page <= nibble_exec_pkg::PAGE_RESET;
        end else if (dec_long) begin
            held_page <= instr_word[nibble_exec_pkg::PAGE_W-1:0];
        end
    end

    // -----------------------------------------------------------------
    // Accumulator and carry
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            accumulator <= nibble_exec_pkg::ACC_RESET;
        end else if (acc_write) begin
            accumulator <= alu_bus.result;
        end else if (acc_ext_load) begin
            accumulator <= acc_ext_data;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            carry_flag <= nibble_exec_pkg::CARRY_RESET;
        end else if (dec_add_carry) begin
            carry_flag <= alu_bus.carry_out;
        end
    end

    // -----------------------------------------------------------------
    // Program counter loads
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_load <= 1'b0;
        end else begin
            pc_load <= jump_taken;
        end
    end

    // -----------------------------------------------------------------
    // Jump target registers
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            program_page_part <= nibble_exec_pkg::PAGE_RESET;
        end else if (dec_in_page) begin
            program_page_part <= current_page;
        end else if (take_long_second) begin
            program_page_part <= held_page;
        end else if (take_indirect_second) begin
            program_page_part <= indirect_page;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            program_offset_part <= nibble_exec_pkg::OFFSET_RESET;
        end else if (dec_in_page) begin
            program_offset_part <= offset_field(instr_word);
        end else if (take_long_second) begin
            program_offset_part <= offset_field(instr_word);
        end else if (take_indirect_second) begin
            program_offset_part <= {d_register, accumulator};
        end
    end
endmodule

`default_nettype wire

// >>> verif/nibble_exec_monitor.sv
// Checker for the nibble execution block.
// Assumes a bind onto every nibble_exec instance.
`timescale 1ns/10ps
`default_nettype none
module nibble_exec_monitor (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [9:0] instr_word,
    input wire logic [4:0] current_page,
    input wire logic [5:0] data_pointer,
    input wire logic [3:0] pointed_memory_nibble,
    input wire logic [2:0] d_register,
    input wire logic [5:0] ram_read_addr,
    input wire logic [3:0] accumulator,
    input wire logic carry_flag,
    input wire logic pc_load,
    input wire logic [4:0] program_page_part,
    input wire logic [6:0] program_offset_part,
    input wire logic second_word_wait
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic first;
    assign first = instr_valid && !second_word_wait;
    sequence take(logic [9:0] op);
        first && instr_word == op;
    endsequence
    sequence long_pair;
        first && instr_word[9:5] == 5'h07 ##1 instr_valid && instr_word[9:7] == 3'h4;
    endsequence
    sequence ind_pair;
        take(10'h010) ##1 instr_valid && instr_word[9:7] == 3'h4;
    endsequence
    add_memory_a: assert property (take(10'h00a) |=>
        accumulator == $past(accumulator + pointed_memory_nibble) && $stable(carry_flag)) else $error("add wrong");
    add_carry_a: assert property (take(10'h00b) |=>
        {carry_flag, accumulator} == $past({1'b0, accumulator} + pointed_memory_nibble + carry_flag))
        else $error("add with carry wrong");
    and_memory_a: assert property (take(10'h018) |=>
        accumulator == $past(accumulator & pointed_memory_nibble) && $stable(carry_flag)) else $error("and wrong");
    in_page_a: assert property (first && instr_word[9:7] == 3'h3 |=> pc_load &&
        program_page_part == $past(current_page) && program_offset_part == $past(instr_word[6:0]))
        else $error("in-page jump wrong");
    long_first_a: assert property (first && instr_word[9:5] == 5'h07 |=>
        second_word_wait && !pc_load) else $error("long jump not waiting");
    long_jump_a: assert property (long_pair |=> pc_load && program_page_part == $past(instr_word[4:0], 2) &&
        program_offset_part == $past(instr_word[6:0]) && !second_word_wait) else $error("long jump wrong");
    bad_second_a: assert property (second_word_wait && instr_valid && instr_word[9:7] != 3'h4 |=>
        !pc_load && !second_word_wait) else $error("bad second word taken");
    indirect_jump_a: assert property (ind_pair |=> pc_load && $stable(carry_flag) &&
        program_page_part == $past({instr_word[6], instr_word[3:0]}) &&
        program_offset_part == $past({d_register, accumulator})) else $error("indirect jump wrong");
    ram_address_a: assert property (ram_read_addr == data_pointer) else $error("ram address wrong");
endmodule
bind nibble_exec nibble_exec_monitor nibble_exec_monitor_i (.mclk, .sys_rst, .instr_valid, .instr_word,
    .current_page, .data_pointer, .pointed_memory_nibble, .d_register, .ram_read_addr, .accumulator,
    .carry_flag, .pc_load, .program_page_part, .program_offset_part, .second_word_wait);
`default_nettype wire

// >>> verif/ram_model.sv
// Read-only data RAM model with same-cycle return.
// Assumes the block drives ram_read_addr.
`timescale 1ns/10ps
`default_nettype none
module ram_model (
    input wire logic [5:0] ram_read_addr,
    output logic [3:0] pointed_memory_nibble
);
    always_comb pointed_memory_nibble = 4'(ram_read_addr * 5 + 3);
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the nibble execution block.
// Assumes the RAM model returns address times 5 plus 3.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic mclk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, acc_ext_load = 1'b0, carry_flag, pc_load;
    logic second_word_wait;
    logic [9:0] instr_word = 10'h000;
    logic [4:0] current_page = 5'h00, program_page_part, p;
    logic [5:0] data_pointer = 6'h00, ram_read_addr;
    logic [3:0] pointed_memory_nibble, acc_ext_data = 4'h0, accumulator, m, exp_acc;
    logic [2:0] d_register = 3'h0;
    logic [6:0] program_offset_part, a;
    logic exp_cy;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    nibble_exec nibble_exec_i (.mclk, .sys_rst, .instr_valid, .instr_word, .current_page, .data_pointer,
        .pointed_memory_nibble, .d_register, .acc_ext_load, .acc_ext_data, .ram_read_addr, .accumulator,
        .carry_flag, .pc_load, .program_page_part, .program_offset_part, .second_word_wait);
    ram_model ram_model_i (.ram_read_addr, .pointed_memory_nibble);
    // ------------------------------------------------------------
    // Clock, timeout and tasks
    // ------------------------------------------------------------
    initial forever #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            test_done;
        end
    end
    task test_done;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task chk(input logic [19:0] got, input logic [19:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task word(input logic [9:0] w);
        @(negedge mclk);
        acc_ext_load = 0;
        instr_valid = 1;
        instr_word = w;
    endtask
    task idle;
        @(negedge mclk);
        instr_valid = 0;
    endtask
    task chk_reset;
        chk({accumulator, carry_flag, pc_load, program_page_part, program_offset_part, second_word_wait}, 0);
        exp_acc = 4'h0;
        exp_cy = 1'b0;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(63));
        repeat (6) @(negedge mclk);
        sys_rst = 0;
        chk_reset;
        for (int k = 0; k < 63; k++) begin
            @(negedge mclk);
            data_pointer = 6'($urandom);
            d_register = 3'($urandom);
            current_page = 5'($urandom);
            p = 5'($urandom);
            a = (k < 7) ? 7'h7f : 7'($urandom);
            m = 4'(data_pointer * 5 + 3);
            if ($urandom % 2) begin
                acc_ext_load = 1;
                acc_ext_data = (k < 7) ? 4'hf : 4'($urandom);
                exp_acc = acc_ext_data;
            end
            case (k % 7)
                0: begin word(10'h00a); idle; exp_acc = exp_acc + m; end
                1: begin word(10'h00b); idle; {exp_cy, exp_acc} = {1'b0, exp_acc} + m + exp_cy; end
                2: begin word(10'h018); idle; exp_acc = exp_acc & m; end
                3: begin
                    word(10'h180 | a);
                    idle;
                    chk({pc_load, program_page_part, program_offset_part}, {1'b1, current_page, a});
                end
                4: begin
                    word({5'h07, p});
                    if (k > 35) idle;
                    word({3'h4, a});
                    chk({second_word_wait, pc_load}, 2'b10);
                    idle;
                    chk({pc_load, program_page_part, program_offset_part}, {1'b1, p, a});
                end
                5: begin
                    word(10'h010);
                    word({3'h4, p[4], 2'b00, p[3:0]});
                    idle;
                    chk({pc_load, program_page_part, program_offset_part, carry_flag},
                        {1'b1, p, d_register, exp_acc, exp_cy});
                end
                default: begin
                    word({5'h07, p});
                    word(10'h180 | a);
                    idle;
                    chk({pc_load, second_word_wait}, 2'b00);
                end
            endcase
            chk({accumulator, carry_flag}, {exp_acc, exp_cy});
            chk(ram_read_addr, data_pointer);
            if (k == 30) begin
                sys_rst = 1;
                @(negedge mclk);
                sys_rst = 0;
                chk_reset;
            end
            $display("test %0d done", k);
        end
        test_done;
    end
endmodule
`default_nettype wire
